/* isd_pkg.sv */
// shared constants and types for the i2c slave byte and interrupt block
package isd_pkg;

  // apb address width and register byte offsets
  localparam int ISD_AW = 12;
  localparam logic [ISD_AW-1:0] ISD_OFS_REQ = 12'h004;
  localparam logic [ISD_AW-1:0] ISD_OFS_BYTE = 12'h008;
  localparam logic [ISD_AW-1:0] ISD_OFS_MASK = 12'h00C;
  localparam logic [ISD_AW-1:0] ISD_OFS_RAW = 12'h010;
  localparam logic [ISD_AW-1:0] ISD_OFS_MIS = 12'h014;
  localparam logic [ISD_AW-1:0] ISD_OFS_CLR = 12'h018;

  // field positions
  localparam int ISD_PEND_BIT = 0;
  localparam int ISD_REQ_RX_BIT = 0;
  localparam int ISD_REQ_TX_BIT = 1;
  localparam int ISD_DIR_BIT = 0;

  // reset values and counts
  localparam logic [7:0] ISD_BYTE_RST = 8'h00;
  localparam logic ISD_MASK_RST = 1'h0;
  localparam logic ISD_RAW_RST = 1'h0;
  localparam logic [2:0] ISD_LAST_BIT = 3'h7;
  localparam logic [6:0] ISD_OWN_ADDR_DEF = 7'h2A;

  // link-side states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_HOLD,
    ST_RX_ACK,
    ST_TX_WAIT,
    ST_TX,
    ST_TX_ACK
  } isd_state_t;

  // whole module state
  typedef struct packed {
    isd_state_t state;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic full;
    logic dir;
    logic [7:0] slave_byte;
    logic mask;
    logic raw;
    logic transmit_request_flag;
    logic receive_request_flag;
    logic scl_oe;
    logic sda_oe;
    logic irq;
    logic [31:0] prdata;
  } isd_regs_t;

  localparam isd_regs_t ISD_REGS_RST = '{
    state: ST_IDLE, scl_s1: 1'h1, scl_s2: 1'h1, scl_s3: 1'h1,
    sda_s1: 1'h1, sda_s2: 1'h1, sda_s3: 1'h1, cnt: 3'h0, shift: 8'h00,
    full: 1'h0, dir: 1'h0, slave_byte: ISD_BYTE_RST, mask: ISD_MASK_RST,
    raw: ISD_RAW_RST, transmit_request_flag: 1'h0, receive_request_flag: 1'h0, scl_oe: 1'h0, sda_oe: 1'h0,
    irq: 1'h0, prdata: 32'h0000_0000};

endpackage

/* isd_slave_regs.sv */
// i2c slave byte register, request flags, clock stretching and interrupt logic
//
// Overview of operation
// R1 - byte field bits 7:0, resets to zero
// R2 - one byte field serves receive and transmit
// R3 - mask bit 0 gates raw pending onto interrupt
// R4 - raw status bit 0 shows pending, ignores mask
// R5 - masked status bit 0 is raw and mask
// R6 - writing one to clear bit drops raw flag
// R7 - clear register reads carry no meaning
// R8 - unused upper bits read only, software preserves
// R9 - transmit request stretches clock until byte written
// R10 - receive request stretches clock until byte read
// R11 - new transmit or receive request sets raw flag
`timescale 1ns/10ps
module isd_slave_regs #(
  parameter logic [6:0] OWN_ADDR = isd_pkg::ISD_OWN_ADDR_DEF
) (
  input wire logic MCLK, // system clock, 200 mhz
  input wire logic SYS_RST, // synchronous reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [isd_pkg::ISD_AW-1:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready, always high
  output logic PSLVERR, // apb error on unmapped address
  input wire logic SCL_IN, // bus clock level
  output logic SCL_OUT, // bus clock drive value
  output logic SCL_OE, // bus clock pulled low while high
  input wire logic SDA_IN, // bus data level
  output logic SDA_OUT, // bus data drive value
  output logic SDA_OE, // bus data pulled low while high
  output logic TRANSMIT_REQUEST_FLAG, // byte wanted for transmit
  output logic RECEIVE_REQUEST_FLAG, // received byte waiting
  output logic IRQ // level interrupt
);
  import isd_pkg::*;

  isd_regs_t q;
  isd_regs_t n;
  logic apb_setup;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic byte_wr;
  logic byte_rd;
  logic clr_wr;
  logic new_req;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [31:0] rd_mux;

  // apb phase decode
  assign apb_setup = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign rd_acc = PSEL & PENABLE & ~PWRITE;
  assign byte_wr = wr_acc & (PADDR == ISD_OFS_BYTE);
  assign byte_rd = rd_acc & (PADDR == ISD_OFS_BYTE);
  assign clr_wr = wr_acc & (PADDR == ISD_OFS_CLR) & PWDATA[ISD_PEND_BIT];

  // address map check
  assign mapped = (PADDR == ISD_OFS_REQ) | (PADDR == ISD_OFS_BYTE) | (PADDR == ISD_OFS_MASK) |
                  (PADDR == ISD_OFS_RAW) | (PADDR == ISD_OFS_MIS) | (PADDR == ISD_OFS_CLR);

  // bus events from the second and third sync stages only
  assign scl_rise = q.scl_s2 & ~q.scl_s3;
  assign scl_fall = ~q.scl_s2 & q.scl_s3;
  assign bus_start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign bus_stop = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;

  // read data select, upper bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      ISD_OFS_REQ: begin
        rd_mux[ISD_REQ_RX_BIT] = q.receive_request_flag;
        rd_mux[ISD_REQ_TX_BIT] = q.transmit_request_flag;
      end
      ISD_OFS_BYTE: rd_mux[7:0] = q.slave_byte; // R2
      ISD_OFS_MASK: rd_mux[ISD_PEND_BIT] = q.mask;
      ISD_OFS_RAW: rd_mux[ISD_PEND_BIT] = q.raw; // R4
      ISD_OFS_MIS: rd_mux[ISD_PEND_BIT] = q.raw & q.mask; // R5
      ISD_OFS_CLR: rd_mux = 32'h0000_0000; // R7
      default: rd_mux = 32'h0000_0000; // R8
    endcase
  end

  // next state of the whole block
  always_comb begin
    n = q;
    new_req = 1'h0;
    // two-stage synchronisers plus an edge stage
    n.scl_s1 = SCL_IN;
    n.scl_s2 = q.scl_s1;
    n.scl_s3 = q.scl_s2;
    n.sda_s1 = SDA_IN;
    n.sda_s2 = q.sda_s1;
    n.sda_s3 = q.sda_s2;
    // register writes and read capture
    if (apb_setup) begin
      n.prdata = rd_mux;
    end
    if (byte_wr) begin
      n.slave_byte = PWDATA[7:0]; // R2
    end
    if (wr_acc && (PADDR == ISD_OFS_MASK)) begin
      n.mask = PWDATA[ISD_PEND_BIT]; // R3
    end
    if (byte_rd) begin
      n.receive_request_flag = 1'h0; // R10
    end
    // link sequencer
    case (q.state)
      ST_IDLE: begin
        n.sda_oe = 1'h0;
        n.scl_oe = 1'h0;
      end
      ST_ADDR: begin
        if (scl_rise) begin
          n.shift = {q.shift[6:0], q.sda_s2};
          n.cnt = 3'(q.cnt + 3'h1);
          n.full = (q.cnt == ISD_LAST_BIT);
        end else if (scl_fall && q.full) begin
          n.full = 1'h0;
          if (q.shift[7:1] == OWN_ADDR) begin
            n.dir = q.shift[ISD_DIR_BIT];
            n.sda_oe = 1'h1;
            n.state = ST_ADDR_ACK;
          end else begin
            n.state = ST_IDLE;
          end
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall) begin
          n.sda_oe = 1'h0;
          n.cnt = 3'h0;
          if (q.dir) begin
            n.transmit_request_flag = 1'h1; // R9
            n.scl_oe = 1'h1; // R9
            n.state = ST_TX_WAIT;
          end else begin
            n.state = ST_RX;
          end
        end
      end
      ST_RX: begin
        if (scl_rise) begin
          n.shift = {q.shift[6:0], q.sda_s2};
          n.cnt = 3'(q.cnt + 3'h1);
          if (q.cnt == ISD_LAST_BIT) begin
            n.slave_byte = {q.shift[6:0], q.sda_s2}; // R1
            n.receive_request_flag = 1'h1; // R10
            n.full = 1'h1;
          end
        end else if (scl_fall && q.full) begin
          n.full = 1'h0;
          if (n.receive_request_flag) begin
            n.scl_oe = 1'h1; // R10
            n.state = ST_RX_HOLD;
          end else begin
            n.sda_oe = 1'h1;
            n.state = ST_RX_ACK;
          end
        end
      end
      ST_RX_HOLD: begin
        if (!q.receive_request_flag) begin
          n.scl_oe = 1'h0; // R10
          n.sda_oe = 1'h1;
          n.state = ST_RX_ACK;
        end
      end
      ST_RX_ACK: begin
        if (scl_fall) begin
          n.sda_oe = 1'h0;
          n.cnt = 3'h0;
          n.state = ST_RX;
        end
      end
      ST_TX_WAIT: begin
        if (byte_wr) begin
          n.shift = PWDATA[7:0];
          n.sda_oe = ~PWDATA[7];
          n.scl_oe = 1'h0; // R9
          n.transmit_request_flag = 1'h0; // R9
          n.cnt = 3'h0;
          n.state = ST_TX;
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (q.cnt == ISD_LAST_BIT) begin
            n.sda_oe = 1'h0;
            n.state = ST_TX_ACK;
          end else begin
            n.cnt = 3'(q.cnt + 3'h1);
            n.shift = {q.shift[6:0], 1'h0};
            n.sda_oe = ~q.shift[6];
          end
        end
      end
      ST_TX_ACK: begin
        if (scl_rise) begin
          n.full = ~q.sda_s2;
        end else if (scl_fall) begin
          n.full = 1'h0;
          if (q.full) begin
            n.transmit_request_flag = 1'h1; // R9
            n.scl_oe = 1'h1;
            n.state = ST_TX_WAIT;
          end else begin
            n.state = ST_IDLE;
          end
        end
      end
      default: n.state = ST_IDLE;
    endcase
    // start and stop override any state, a pending received byte is kept
    if (bus_start || bus_stop) begin
      n.state = bus_start ? ST_ADDR : ST_IDLE;
      n.cnt = 3'h0;
      n.full = 1'h0;
      n.transmit_request_flag = 1'h0;
      n.scl_oe = 1'h0;
      n.sda_oe = 1'h0;
    end
    // sticky pending flag, a new request beats a clear in the same cycle
    new_req = (n.transmit_request_flag & ~q.transmit_request_flag) | (n.receive_request_flag & ~q.receive_request_flag);
    if (clr_wr) begin
      n.raw = 1'h0; // R6
    end
    if (new_req) begin
      n.raw = 1'h1; // R11
    end
    n.irq = n.raw & n.mask; // R3
  end

  // state register
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      q <= ISD_REGS_RST; // R1
    end else begin
      q <= n;
    end
  end

  // port drive
  assign PRDATA = q.prdata;
  assign PREADY = 1'h1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign SCL_OUT = 1'h0;
  assign SDA_OUT = 1'h0;
  assign SCL_OE = q.scl_oe;
  assign SDA_OE = q.sda_oe;
  assign TRANSMIT_REQUEST_FLAG = q.transmit_request_flag;
  assign RECEIVE_REQUEST_FLAG = q.receive_request_flag;
  assign IRQ = q.irq;

  // checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_wr(logic [ISD_AW-1:0] a);
    PSEL && PENABLE && PWRITE && (PADDR == a);
  endsequence

  sequence s_rd_setup(logic [ISD_AW-1:0] a);
    PSEL && !PENABLE && !PWRITE && (PADDR == a);
  endsequence

  property p_byte_reset;
    $past(SYS_RST) |-> (q.slave_byte == ISD_BYTE_RST) && !q.mask && !q.raw;
  endproperty
  a_byte_reset: assert property (p_byte_reset) else $error("byte or mask not zero after reset"); // R1

  property p_byte_write;
    s_wr(ISD_OFS_BYTE) ##1 !$past(scl_rise) |-> q.slave_byte == $past(PWDATA[7:0]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write not stored"); // R2

  property p_irq_gate;
    (!q.mask |-> !IRQ) and (s_wr(ISD_OFS_MASK) |=> IRQ == ($past(PWDATA[ISD_PEND_BIT]) && q.raw));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not raw gated by mask"); // R3

  property p_raw_read;
    s_rd_setup(ISD_OFS_RAW) |=> PRDATA == {31'h0000_0000, $past(q.raw)};
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw status read wrong"); // R4

  property p_mis_read;
    s_rd_setup(ISD_OFS_MIS) |=> PRDATA[ISD_PEND_BIT] == $past(q.raw && q.mask);
  endproperty
  a_mis_read: assert property (p_mis_read) else $error("masked status read wrong"); // R5

  property p_clear_one;
    s_wr(ISD_OFS_CLR) and (PWDATA[ISD_PEND_BIT] && !new_req) |=> !q.raw;
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("clear write left flag set"); // R6

  property p_clear_zero;
    s_wr(ISD_OFS_CLR) and (!PWDATA[ISD_PEND_BIT] && q.raw) |=> q.raw;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("zero clear write changed flag"); // R6

  property p_upper_zero;
    PSEL && !PENABLE |=> PRDATA[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero"); // R8

  property p_tx_stretch;
    (q.state == ST_TX_WAIT) && !byte_wr |=> (SCL_OE && TRANSMIT_REQUEST_FLAG) [*1];
  endproperty
  a_tx_stretch: assert property (p_tx_stretch) else $error("transmit stretch released early"); // R9

  sequence s_rx_hold;
    (q.state == ST_RX_HOLD) && q.receive_request_flag && !byte_rd;
  endsequence

  property p_rx_stretch;
    s_rx_hold |=> SCL_OE && RECEIVE_REQUEST_FLAG;
  endproperty
  a_rx_stretch: assert property (p_rx_stretch) else $error("receive stretch released early"); // R10

  property p_req_raises;
    ($rose(q.transmit_request_flag) || $rose(q.receive_request_flag)) |-> q.raw ##1 (q.raw || $past(clr_wr));
  endproperty
  a_req_raises: assert property (p_req_raises) else $error("new request did not set pending"); // R11

  property p_req_read;
    s_rd_setup(ISD_OFS_REQ) |=> PRDATA == {30'h0000_0000, $past(q.transmit_request_flag), $past(q.receive_request_flag)};
  endproperty
  a_req_read: assert property (p_req_read) else $error("request status read wrong"); // R9

  property p_tx_release;
    (q.state == ST_TX_WAIT) && byte_wr |=> !SCL_OE && !TRANSMIT_REQUEST_FLAG;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("byte write did not release stretch"); // R9

endmodule

/* isd_i2c_master.sv */
// i2c bus master model on open-drain clock and data lines
`timescale 1ns/10ps
module isd_i2c_master (
  input wire logic clk, // system clock
  input wire logic scl, // resolved clock line
  input wire logic sda, // resolved data line
  output logic scl_low, // pulls clock line low
  output logic sda_low // pulls data line low
);
  logic hung = 1'b0;
  // lines released at start
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // half of the 80 ns link period
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  // release clock, wait out a stretch under a bound
  task automatic rise();
    int n;
    scl_low <= 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) hung = 1'b1;
  endtask
  // start condition, clock left low
  task automatic start();
    sda_low <= 1'b0;
    rise();
    half();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
  endtask
  // stop condition, both lines released
  task automatic stop();
    sda_low <= 1'b1;
    half();
    rise();
    half();
    sda_low <= 1'b0;
    half();
  endtask
  // one bit out, data set while clock low
  task automatic put_bit(input logic b);
    sda_low <= ~b;
    half();
    rise();
    half();
    scl_low <= 1'b1;
  endtask
  // one bit in, sampled at end of clock high
  task automatic get_bit(output logic b);
    sda_low <= 1'b0;
    half();
    rise();
    half();
    b = sda;
    scl_low <= 1'b1;
  endtask
  // byte out msb first, then slave acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(ack);
  endtask
  // byte in msb first, then our acknowledge
  task automatic get_byte(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) get_bit(b[i]);
    put_bit(ack);
  endtask
endmodule

/* test_isd_slave_regs.sv */
// testbench for the i2c slave byte and interrupt block
`timescale 1ns/10ps
module test_isd_slave_regs;
  import isd_pkg::*;
  logic MCLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [ISD_AW-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, d, r, exp_byte = '0, exp_mask = '0, exp_raw = '0;
  logic PREADY, PSLVERR, SCL_OE, SDA_OE, TRANSMIT_REQUEST_FLAG, RECEIVE_REQUEST_FLAG, IRQ;
  logic m_scl, m_sda, e, ack;
  logic [7:0] rb, rb2;
  wire scl = ~(m_scl | SCL_OE);
  wire sda = ~(m_sda | SDA_OE);
  int n_fail = 0, total_checks = 0, seed = 32'hfc608475;
  // 200 mhz clock
  always #2.5 MCLK = ~MCLK;
  isd_slave_regs dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SCL_IN(scl), .SCL_OUT(), .SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(),
    .SDA_OE(SDA_OE), .TRANSMIT_REQUEST_FLAG(TRANSMIT_REQUEST_FLAG),
    .RECEIVE_REQUEST_FLAG(RECEIVE_REQUEST_FLAG), .IRQ(IRQ));
  isd_i2c_master m_u (.clk(MCLK), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
  // closing report
  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one apb transfer, setup then access until ready
  task apb(input logic w, input logic [ISD_AW-1:0] a, input logic [31:0] wd);
    int n;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      give_verdict();
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // bounded wait for a request flag
  task wait_flag(input logic tx);
    int n;
    n = 0;
    while ((tx ? TRANSMIT_REQUEST_FLAG : RECEIVE_REQUEST_FLAG) !== 1'b1) begin
      @(posedge MCLK);
      n++;
      if (n > 5000) begin
        n_fail++;
        give_verdict();
      end
    end
  endtask
  // compare every register except the request register, and the interrupt, with the model
  task check_all();
    apb(1'b0, ISD_OFS_MASK, '0);
    chk("mask", exp_mask, r);
    apb(1'b0, ISD_OFS_RAW, '0);
    chk("raw", exp_raw, r);
    apb(1'b0, ISD_OFS_MIS, '0);
    chk("masked", exp_raw & exp_mask, r);
    apb(1'b0, ISD_OFS_CLR, '0);
    chk("clear read", '0, r);
    chk("irq", exp_raw & exp_mask, {31'h0, IRQ});
    apb(1'b0, ISD_OFS_BYTE, '0);
    chk("byte", exp_byte, r);
    chk("mapped err", 0, {31'h0, e});
  endtask
  // write random words and track what must stick
  task wr(input logic [ISD_AW-1:0] a, input logic b0);
    d = $random(seed);
    d[0] = b0;
    apb(1'b1, a, d);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    check_all();
    apb(1'b0, 12'h000, '0);
    chk("unmapped err", 1, {31'h0, e});
    $display("test reset done");
    wr(ISD_OFS_RAW, 1'b1);
    wr(ISD_OFS_MIS, 1'b1);
    wr(ISD_OFS_BYTE, 1'b1);
    exp_byte = {24'h0, d[7:0]};
    wr(ISD_OFS_MASK, 1'b1);
    exp_mask = 1;
    check_all();
    $display("test registers done");
    m_u.start();
    m_u.put_byte({ISD_OWN_ADDR_DEF, 1'b0}, ack);
    chk("addr ack", 0, {31'h0, ack});
    d = $random(seed);
    fork
      m_u.put_byte(d[7:0], ack);
      begin
        wait_flag(1'b0);
        apb(1'b0, ISD_OFS_REQ, '0);
        chk("req rx", 1, r);
        exp_raw = 1;
        exp_byte = {24'h0, d[7:0]};
        check_all();
      end
    join
    chk("data ack", 0, {31'h0, ack});
    chk("rx flag", 0, {31'h0, RECEIVE_REQUEST_FLAG});
    m_u.stop();
    wr(ISD_OFS_MASK, 1'b0);
    exp_mask = 0;
    check_all();
    wr(ISD_OFS_CLR, 1'b0);
    check_all();
    wr(ISD_OFS_CLR, 1'b1);
    exp_raw = 0;
    check_all();
    $display("test receive done");
    m_u.start();
    m_u.put_byte({ISD_OWN_ADDR_DEF, 1'b1}, ack);
    chk("addr ack tx", 0, {31'h0, ack});
    fork
      begin
        m_u.get_byte(1'b0, rb);
        m_u.get_byte(1'b1, rb2);
      end
      begin
        wait_flag(1'b1);
        chk("tx stretch", 1, {31'h0, SCL_OE});
        apb(1'b0, ISD_OFS_RAW, '0);
        exp_raw = 1;
        chk("raw tx", exp_raw, r);
        apb(1'b0, ISD_OFS_REQ, '0);
        chk("req tx", 2, r);
        chk("irq tx", 0, {31'h0, IRQ});
        wr(ISD_OFS_BYTE, d[0]);
        exp_byte = {24'h0, d[7:0]};
        @(posedge MCLK);
        chk("tx release", 0, {31'h0, TRANSMIT_REQUEST_FLAG});
        wait_flag(1'b1);
        wr(ISD_OFS_BYTE, d[1]);
      end
    join
    chk("tx byte", exp_byte, {24'h0, rb});
    exp_byte = {24'h0, d[7:0]};
    chk("tx byte 2", exp_byte, {24'h0, rb2});
    m_u.stop();
    chk("tx flag", 0, {31'h0, TRANSMIT_REQUEST_FLAG});
    check_all();
    chk("master hang", 0, {31'h0, m_u.hung});
    $display("test transmit done");
    give_verdict();
  end
endmodule
